//--- logic/pca_defines.svh
// Register offsets, field positions, reset values and frame counts of the config bank
`ifndef PCA_DEFINES_SVH
`define PCA_DEFINES_SVH

`define PCA_ADDR_W          15
`define PCA_DATA_W          16
`define PCA_OFS_PAT_CTL     15'h0045
`define PCA_OFS_TW_CFG      15'h0047
`define PCA_OFS_CHAN_FIRST  15'h0050
`define PCA_OFS_CHAN_LAST   15'h005B
`define PCA_OFS_CH4_DELAY   15'h0050
`define PCA_OFS_CH4_BEGIN   15'h0051
`define PCA_OFS_CH4_END     15'h0052
`define PCA_OFS_CH4_CYCLES  15'h0053
`define PCA_OFS_CH3_DELAY   15'h0054
`define PCA_OFS_CH3_BEGIN   15'h0055
`define PCA_OFS_CH3_END     15'h0056
`define PCA_OFS_CH3_CYCLES  15'h0057
`define PCA_OFS_CH2_DELAY   15'h0058
`define PCA_OFS_CH2_BEGIN   15'h0059
`define PCA_OFS_CH2_END     15'h005A
`define PCA_OFS_CH2_CYCLES  15'h005B
`define PCA_FLD_DELAY       2'h0
`define PCA_FLD_BEGIN       2'h1
`define PCA_FLD_END         2'h2
`define PCA_FLD_CYCLES      2'h3
`define PCA_PTR_MSB         15
`define PCA_PTR_LSB         4
`define PCA_TW_EN_BIT       0
`define PCA_SHIFT_MSB       4
`define PCA_RST_DELAY       16'h0000
`define PCA_RST_PTR         16'h0000
`define PCA_RST_CYCLES      16'h0001
`define PCA_RST_CFG         16'h0000
`define PCA_SHIFT_MAX       5'h10
`define PCA_INSTR_BITS      5'h10
`define PCA_FRAME_BITS      6'h20
`define PCA_RW_BIT          15

`endif

//--- logic/pca_pkg.sv
// Types shared by the pattern channel configuration bank
package pca_pkg;

	typedef struct packed {
		logic [15:0] begin_delay;
		logic [11:0] begin_pointer;
		logic [11:0] end_pointer;
		logic [15:0] tone_cycles;
	} pca_chan_s;

	typedef struct packed {
		logic        strobe;
		logic [14:0] addr;
		logic [15:0] data;
	} pca_wr_s;

	typedef enum logic [2:0] {
		SPI_IDLE  = 3'b001,
		SPI_INSTR = 3'b010,
		SPI_DATA  = 3'b100
	} pca_spi_e;

endpackage : pca_pkg

//--- logic/pca_spi_slave.sv
// Serial configuration port: 16-bit instruction then 16-bit data, MSB first
`timescale 1ns/100ps
`include "pca_defines.svh"

module pca_spi_slave (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             cs_n_i,
	input  wire logic             sclk_i,
	input  wire logic             sdi_i,
	output logic                  sdo_o,
	output logic                  sdo_oe_o,
	output logic [14:0]           rd_addr_o,
	input  wire logic [15:0]      rd_data_i,
	output pca_pkg::pca_wr_s      wr_o
);

	pca_pkg::pca_spi_e state_q, state_d;
	logic       sclk_q, sclk_d;
	logic [5:0] cnt_q, cnt_d;
	logic [15:0] sh_q, sh_d;
	logic [15:0] rdsh_q, rdsh_d;
	logic        read_q, read_d;
	logic [14:0] addr_q, addr_d;
	logic        sdo_q, sdo_d;
	pca_pkg::pca_wr_s wr_q, wr_d;
	logic        rise;
	logic        fall;

	assign rise      = sclk_i & ~sclk_q;
	assign fall      = ~sclk_i & sclk_q;
	assign rd_addr_o = sh_q[14:0];
	assign sdo_o     = sdo_q;
	// Drive only during the data half of a read
	assign sdo_oe_o  = (state_q == pca_pkg::SPI_DATA) & read_q & ~cs_n_i;
	assign wr_o      = wr_q;

	always_comb
	begin
		state_d = state_q;
		sclk_d  = sclk_i;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		rdsh_d  = rdsh_q;
		read_d  = read_q;
		addr_d  = addr_q;
		sdo_d   = sdo_q;
		wr_d    = '0;
		if (cs_n_i)
		begin
			state_d = pca_pkg::SPI_IDLE;
			cnt_d   = 6'h00;
		end
		else
		begin
			case (state_q)
				pca_pkg::SPI_IDLE:
					state_d = pca_pkg::SPI_INSTR;
				pca_pkg::SPI_INSTR:
					if (rise)
					begin
						sh_d  = {sh_q[14:0], sdi_i};
						cnt_d = cnt_q + 6'h01;
						if (cnt_q[4:0] == (`PCA_INSTR_BITS - 5'h01))
						begin
							read_d  = sh_q[14];
							addr_d  = {sh_q[13:0], sdi_i};
							state_d = pca_pkg::SPI_DATA;
						end
					end
				pca_pkg::SPI_DATA:
				begin
					// Load only before the first fall, else the word reloads and repeats its MSB
					if ((cnt_q == {1'b0, `PCA_INSTR_BITS}) && sclk_q)
						rdsh_d = rd_data_i;
					if (rise)
					begin
						sh_d  = {sh_q[14:0], sdi_i};
						cnt_d = cnt_q + 6'h01;
						if (cnt_q == (`PCA_FRAME_BITS - 6'h01))
						begin
							wr_d.strobe = ~read_q;
							wr_d.addr   = addr_q;
							wr_d.data   = {sh_q[14:0], sdi_i};
							cnt_d       = 6'h00;
							state_d     = pca_pkg::SPI_INSTR;
						end
					end
					if (fall & read_q)
					begin
						sdo_d  = rdsh_q[15];
						rdsh_d = {rdsh_q[14:0], 1'b0};
					end
				end
				default:
					state_d = pca_pkg::SPI_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= pca_pkg::SPI_IDLE;
			sclk_q  <= 1'b0;
			cnt_q   <= 6'h00;
			sh_q    <= 16'h0000;
			rdsh_q  <= 16'h0000;
			read_q  <= 1'b0;
			addr_q  <= 15'h0000;
			sdo_q   <= 1'b0;
			wr_q    <= '0;
		end
		else
		begin
			state_q <= state_d;
			sclk_q  <= sclk_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			rdsh_q  <= rdsh_d;
			read_q  <= read_d;
			addr_q  <= addr_d;
			sdo_q   <= sdo_d;
			wr_q    <= wr_d;
		end
	end

endmodule : pca_spi_slave

//--- logic/pca_tw_build.sv
// Tuning word register fed from the register map or from pattern RAM words
`timescale 1ns/100ps
`include "pca_defines.svh"

module pca_tw_build #(
	parameter int TW_W  = 24,
	parameter int RAM_W = 12
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ram_tuning_word_enable_i,
	input  wire logic [4:0]       ram_word_shift_select_i,
	input  wire logic [RAM_W-1:0] ram_data_i,
	input  wire logic             ram_data_valid_i,
	input  wire logic [TW_W-1:0]  map_tuning_word_i,
	output logic [TW_W-1:0]       tone_tuning_word_o
);

	logic [TW_W-1:0] tw_q, tw_d;

	// Top n bits kept, RAM word right behind them, truncated past the LSB
	function automatic logic [TW_W-1:0] assemble(input logic [TW_W-1:0] cur,
	                                             input logic [RAM_W-1:0] ram,
	                                             input logic [4:0] n);
		logic [TW_W+RAM_W-1:0] wide;
		logic [TW_W-1:0]       keep;
		wide = {ram, {TW_W{1'b0}}} >> n;
		keep = cur & ~({TW_W{1'b1}} >> n);
		return keep | wide[TW_W+RAM_W-1:RAM_W];
	endfunction : assemble

	assign tone_tuning_word_o = tw_q;

	always_comb
	begin
		tw_d = tw_q;
		if (!ram_tuning_word_enable_i)
			tw_d = map_tuning_word_i; // RQ8
		else if (ram_data_valid_i && ram_word_shift_select_i <= `PCA_SHIFT_MAX)
			tw_d = assemble(tw_q, ram_data_i, ram_word_shift_select_i); // RQ1 RQ2 RQ3 RQ9
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			tw_q <= '0;
		else
			tw_q <= tw_d;
	end

endmodule : pca_tw_build

//--- logic/pca_config_bank.sv
// Pattern channel configuration bank behind the serial port
`timescale 1ns/100ps
`include "pca_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1 - Codes 7..12: kept top N bits, twelve RAM bits, zero fill below.
// RQ2 - Codes 13..16: kept top N bits, upper RAM bits; others reserved.
// RQ3 - Codes 8 and 9 pad four and three zeros, word stays 24 bits.
// RQ4 - Each channel has a 16-bit begin delay, reset zero.
// RQ5 - Each channel has a 12-bit begin pointer in bits 15:4, reset zero.
// RQ6 - Each channel has a 12-bit end pointer in bits 15:4, reset zero.
// RQ7 - Each channel has a 16-bit tone cycle count, reset one.
// RQ8 - RAM-sourced tuning word needs the enable; otherwise map word used.
// RQ9 - Codes 0..6: RAM bits below top N kept bits, zero fill.
module pca_config_bank #(
	parameter int NCH   = 3,
	parameter int TW_W  = 24,
	parameter int RAM_W = 12
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             cs_n_i,
	input  wire logic             sclk_i,
	input  wire logic             sdi_i,
	output logic                  sdo_o,
	output logic                  sdo_oe_o,
	input  wire logic [RAM_W-1:0] ram_data_i,
	input  wire logic             ram_data_valid_i,
	input  wire logic [TW_W-1:0]  map_tuning_word_i,
	output logic [TW_W-1:0]       tone_tuning_word_o,
	output logic                  ram_tuning_word_enable_o,
	output logic [4:0]            ram_word_shift_select_o,
	output pca_pkg::pca_chan_s    ch4_cfg_o,
	output pca_pkg::pca_chan_s    ch3_cfg_o,
	output pca_pkg::pca_chan_s    ch2_cfg_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [15:0]      chan_q [NCH][4];
	logic [15:0]      chan_d [NCH][4];
	logic [15:0]      pat_ctl_q, pat_ctl_d;
	logic [15:0]      tw_cfg_q, tw_cfg_d;
	logic [14:0]      rd_addr;
	logic [15:0]      rd_data;
	pca_pkg::pca_wr_s wr;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic chan_hit(input logic [14:0] a);
		return (a >= `PCA_OFS_CHAN_FIRST) && (a <= `PCA_OFS_CHAN_LAST);
	endfunction : chan_hit

	// Channel 0 is the highest-numbered DAC, four words apart
	function automatic logic [1:0] chan_index(input logic [14:0] a);
		logic [14:0] rel;
		rel = a - `PCA_OFS_CHAN_FIRST;
		return rel[3:2];
	endfunction : chan_index

	function automatic logic [15:0] field_reset(input logic [1:0] f);
		logic [15:0] v;
		case (f)
			`PCA_FLD_DELAY:  v = `PCA_RST_DELAY;
			`PCA_FLD_BEGIN:  v = `PCA_RST_PTR;
			`PCA_FLD_END:    v = `PCA_RST_PTR;
			`PCA_FLD_CYCLES: v = `PCA_RST_CYCLES;
			default:         v = 16'h0000;
		endcase
		return v;
	endfunction : field_reset

	function automatic pca_pkg::pca_chan_s pack_chan(input logic [15:0] dly,
	                                                 input logic [15:0] bgn,
	                                                 input logic [15:0] fin,
	                                                 input logic [15:0] cyc);
		pca_pkg::pca_chan_s c;
		c.begin_delay   = dly; // RQ4
		c.begin_pointer = bgn[`PCA_PTR_MSB:`PCA_PTR_LSB]; // RQ5
		c.end_pointer   = fin[`PCA_PTR_MSB:`PCA_PTR_LSB]; // RQ6
		c.tone_cycles   = cyc; // RQ7
		return c;
	endfunction : pack_chan

	////////////////////////////////////////////////////////////////////////////////
	// Serial port

	pca_spi_slave u_spi (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.cs_n_i    (cs_n_i),
		.sclk_i    (sclk_i),
		.sdi_i     (sdi_i),
		.sdo_o     (sdo_o),
		.sdo_oe_o  (sdo_oe_o),
		.rd_addr_o (rd_addr),
		.rd_data_i (rd_data),
		.wr_o      (wr)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register writes

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			for (int f = 0; f < 4; f++)
			begin
				chan_d[c][f] = chan_q[c][f];
			end
		end
		pat_ctl_d = pat_ctl_q;
		tw_cfg_d  = tw_cfg_q;
		if (wr.strobe)
		begin
			if (chan_hit(wr.addr))
				chan_d[chan_index(wr.addr)][wr.addr[1:0]] = wr.data; // RQ4 RQ5 RQ6 RQ7
			else if (wr.addr == `PCA_OFS_PAT_CTL)
				pat_ctl_d = wr.data;
			else if (wr.addr == `PCA_OFS_TW_CFG)
				tw_cfg_d = wr.data;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				for (int f = 0; f < 4; f++)
				begin
					chan_q[c][f] <= field_reset(2'(f)); // RQ4 RQ5 RQ6 RQ7
				end
			end
			pat_ctl_q <= `PCA_RST_CFG;
			tw_cfg_q  <= `PCA_RST_CFG;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				for (int f = 0; f < 4; f++)
				begin
					chan_q[c][f] <= chan_d[c][f];
				end
			end
			pat_ctl_q <= pat_ctl_d;
			tw_cfg_q  <= tw_cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads

	// Reserved bits are stored, so software reads back what it wrote
	always_comb
	begin
		rd_data = 16'h0000;
		if (chan_hit(rd_addr))
			rd_data = chan_q[chan_index(rd_addr)][rd_addr[1:0]];
		else if (rd_addr == `PCA_OFS_PAT_CTL)
			rd_data = pat_ctl_q;
		else if (rd_addr == `PCA_OFS_TW_CFG)
			rd_data = tw_cfg_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs to the pattern engine and tone generator

	assign ram_tuning_word_enable_o = pat_ctl_q[`PCA_TW_EN_BIT];
	assign ram_word_shift_select_o  = tw_cfg_q[`PCA_SHIFT_MSB:0];

	assign ch4_cfg_o = pack_chan(chan_q[0][0], chan_q[0][1], chan_q[0][2], chan_q[0][3]);
	assign ch3_cfg_o = pack_chan(chan_q[1][0], chan_q[1][1], chan_q[1][2], chan_q[1][3]);
	assign ch2_cfg_o = pack_chan(chan_q[2][0], chan_q[2][1], chan_q[2][2], chan_q[2][3]);

	// Word follows the map word while the RAM source is disabled, else changes only on a valid RAM word
	pca_tw_build #(
		.TW_W  (TW_W),
		.RAM_W (RAM_W)
	) u_tw (
		.clk_i                    (clk_i),
		.rst_i                    (rst_i),
		.ram_tuning_word_enable_i (pat_ctl_q[`PCA_TW_EN_BIT]), // RQ8
		.ram_word_shift_select_i  (tw_cfg_q[`PCA_SHIFT_MSB:0]), // RQ1 RQ2 RQ9
		.ram_data_i               (ram_data_i),
		.ram_data_valid_i         (ram_data_valid_i),
		.map_tuning_word_i        (map_tuning_word_i),
		.tone_tuning_word_o       (tone_tuning_word_o)
	);

endmodule : pca_config_bank

//--- test/pca_chk.sv
// Port-level assertions for the pattern channel configuration bank
`timescale 1ns/100ps
module pca_chk #(
	parameter int TW_W  = 24,
	parameter int RAM_W = 12
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [RAM_W-1:0] ram_data_i,
	input  wire logic             ram_data_valid_i,
	input  wire logic [TW_W-1:0]  map_tuning_word_i,
	input  wire logic [TW_W-1:0]  tone_tuning_word_o,
	input  wire logic             ram_tuning_word_enable_o,
	input  wire logic [4:0]       ram_word_shift_select_o,
	input  wire pca_pkg::pca_chan_s ch4_cfg_o,
	input  wire pca_pkg::pca_chan_s ch3_cfg_o,
	input  wire pca_pkg::pca_chan_s ch2_cfg_o
);
	logic       take;
	logic [4:0] sh;
	assign take = ram_tuning_word_enable_o && ram_data_valid_i;
	assign sh   = ram_word_shift_select_o;

	// Kept top bits, then RAM word shifted down, truncated at the word width
	function automatic logic [TW_W-1:0] f_tw(logic [TW_W-1:0] w, logic [RAM_W-1:0] r,
		logic [4:0] n);
		logic [2*TW_W-1:0] s;
		s = {r, {(2*TW_W-RAM_W){1'b0}}} >> n;
		return (w & ~({TW_W{1'b1}} >> n)) | s[2*TW_W-1:TW_W];
	endfunction : f_tw

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////
	a_rst_delay: assert property ($fell(rst_i) |->
		(ch4_cfg_o.begin_delay | ch3_cfg_o.begin_delay | ch2_cfg_o.begin_delay) == 16'h0000)
		else $error("begin delay not zero after reset");
	a_rst_ptrs: assert property ($fell(rst_i) |->
		(ch4_cfg_o.begin_pointer | ch3_cfg_o.begin_pointer | ch2_cfg_o.begin_pointer
		| ch4_cfg_o.end_pointer | ch3_cfg_o.end_pointer | ch2_cfg_o.end_pointer) == 12'h000)
		else $error("pointer not zero after reset");
	a_rst_cycles: assert property ($fell(rst_i) |-> ch4_cfg_o.tone_cycles == 16'h0001 &&
		ch3_cfg_o.tone_cycles == 16'h0001 && ch2_cfg_o.tone_cycles == 16'h0001)
		else $error("tone cycles not one after reset");
	a_tw_map: assert property (!ram_tuning_word_enable_o |=>
		tone_tuning_word_o == $past(map_tuning_word_i)) else $error("map word not followed");
	a_tw_low: assert property (take && sh <= 5'h06 |=> tone_tuning_word_o ==
		f_tw($past(tone_tuning_word_o), $past(ram_data_i), $past(sh)))
		else $error("low shift word wrong");
	a_tw_mid: assert property (take && sh inside {[5'h07:5'h0C]} |=> tone_tuning_word_o ==
		f_tw($past(tone_tuning_word_o), $past(ram_data_i), $past(sh)))
		else $error("mid shift word wrong");
	a_tw_high: assert property (take && sh inside {[5'h0D:5'h10]} |=> tone_tuning_word_o ==
		f_tw($past(tone_tuning_word_o), $past(ram_data_i), $past(sh)))
		else $error("high shift word wrong");
	a_tw_hold: assert property (ram_tuning_word_enable_o && !(take && sh <= 5'h10) |=>
		$stable(tone_tuning_word_o)) else $error("tuning word changed without a valid code");
endmodule : pca_chk

bind pca_config_bank pca_chk #(.TW_W(TW_W), .RAM_W(RAM_W)) i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .ram_data_i(ram_data_i),
	.ram_data_valid_i(ram_data_valid_i), .map_tuning_word_i(map_tuning_word_i),
	.tone_tuning_word_o(tone_tuning_word_o),
	.ram_tuning_word_enable_o(ram_tuning_word_enable_o),
	.ram_word_shift_select_o(ram_word_shift_select_o),
	.ch4_cfg_o(ch4_cfg_o), .ch3_cfg_o(ch3_cfg_o), .ch2_cfg_o(ch2_cfg_o)
);

//--- test/pca_spi_host.sv
// Serial host model that frames register reads and writes
`timescale 1ns/100ps
module pca_spi_host (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      sdi_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
	end

	// Fewer than 32 bits aborts the frame; an undriven sdo reads inverted
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd,
		input int nb, output logic [15:0] q);
		logic [31:0] f;
		f = {rd, a, wd};
		q = 16'h0000;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 31; i > 31 - nb; i--)
		begin
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			sdi_o  <= f[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			if (i < 16)
				q[i] = sdo_oe_i ? sdo_i : ~sdo_i;
		end
		repeat (4) @(posedge clk_i);
		sclk_o <= 1'b0;
		sdi_o  <= ~sdi_o;
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask : xfer
endmodule : pca_spi_host

//--- test/pca_config_bank_tb.sv
// Self-checking bench for the pattern channel configuration bank
`timescale 1ns/100ps
module pca_config_bank_tb;
	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               cs_n, sclk, sdi, sdo, sdo_oe;
	logic [11:0]        ram_data = 12'h000;
	logic               ram_valid = 1'b0;
	logic [23:0]        map_tw = 24'h000000;
	logic [23:0]        tone;
	logic               tw_en;
	logic [4:0]         tw_sel;
	pca_pkg::pca_chan_s cfg [3];
	logic [15:0]        rd;
	int                 fail_count = 0;
	int                 n_checks = 0;

	always #10 clk_i = ~clk_i;

	pca_config_bank i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .ram_data_i(ram_data), .ram_data_valid_i(ram_valid),
		.map_tuning_word_i(map_tw), .tone_tuning_word_o(tone),
		.ram_tuning_word_enable_o(tw_en), .ram_word_shift_select_o(tw_sel),
		.ch4_cfg_o(cfg[0]), .ch3_cfg_o(cfg[1]), .ch2_cfg_o(cfg[2])
	);

	pca_spi_host i_host (
		.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk),
		.sdi_o(sdi)
	);

	////////////////////////////////////////
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [14:0] a, input logic [15:0] d);
		i_host.xfer(1'b0, a, d, 32, rd);
	endtask : wr

	task automatic rr(input logic [14:0] a, input logic [15:0] e);
		i_host.xfer(1'b1, a, 16'h0000, 32, rd);
		chk(24'(rd), 24'(e));
	endtask : rr

	function automatic logic [23:0] f_exp(logic [23:0] w, logic [11:0] r, int n);
		logic [23:0] ins;
		ins = (n <= 12) ? 24'({r, 12'h000} >> n) : 24'(r >> (n - 12));
		return (w & ~(24'hFFFFFF >> n)) | ins;
	endfunction : f_exp

	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask : do_reset

	task automatic t_reset;
		for (int k = 0; k < 12; k++)
			rr(15'h0050 + 15'(k), (k % 4 == 3) ? 16'h0001 : 16'h0000);
	endtask : t_reset

	task automatic t_regs;
		for (int k = 0; k < 12; k++)
			wr(15'h0050 + 15'(k), 16'h1111 * 16'(k + 1));
		for (int k = 0; k < 12; k++)
			rr(15'h0050 + 15'(k), 16'h1111 * 16'(k + 1));
		for (int c = 0; c < 3; c++)
		begin
			chk(24'(cfg[c].begin_delay), 24'h1111 * 24'(4 * c + 1));
			chk(24'(cfg[c].begin_pointer), 24'h111 * 24'(4 * c + 2));
			chk(24'(cfg[c].end_pointer), 24'h111 * 24'(4 * c + 3));
			chk(24'(cfg[c].tone_cycles), 24'h1111 * 24'(4 * c + 4));
		end
	endtask : t_regs

	task automatic t_abort;
		i_host.xfer(1'b0, 15'h0050, 16'hFFFF, 20, rd);
		rr(15'h0050, 16'h1111);
		wr(15'h0060, 16'hBEEF);
		rr(15'h0060, 16'h0000);
	endtask : t_abort

	// Walks every shift code plus one reserved code, chaining kept bits
	task automatic t_tw;
		logic [23:0] e;
		map_tw <= 24'hA5C3E1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk(tone, 24'hA5C3E1);
		e = 24'hA5C3E1;
		wr(15'h0045, 16'h0001);
		chk(24'(tw_en), 24'h000001);
		for (int c = 0; c < 18; c++)
		begin
			wr(15'h0047, 16'(c));
			chk(24'(tw_sel), 24'(c));
			@(posedge clk_i);
			ram_data  <= 12'hB6D ^ 12'(c * 7);
			ram_valid <= 1'b1;
			@(posedge clk_i);
			ram_valid <= 1'b0;
			@(negedge clk_i);
			if (c <= 16)
				e = f_exp(e, 12'hB6D ^ 12'(c * 7), c);
			chk(tone, e);
		end
		map_tw <= 24'h3C0F96;
		wr(15'h0045, 16'h0000);
		@(negedge clk_i);
		chk(24'(tw_en), 24'h000000);
		chk(tone, 24'h3C0F96);
	endtask : t_tw

	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (60000) @(posedge clk_i);
		fail_count++;
		$display("wrong value at %0t: run timed out", $time);
		test_done();
	end

	initial
	begin
		do_reset();
		t_reset();
		t_regs();
		t_abort();
		do_reset();
		t_reset();
		t_tw();
		test_done();
	end
endmodule : pca_config_bank_tb
